//--- dv/core_sfr_props.sv
`timescale 1ns/100ps
module core_sfr_props
  import core_sfr_pkg::*;
#(
  parameter int PC_WIDTH = 13,
  parameter int TBL_WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input core_sfr_pkg::data_req_t data_req,
  input logic [7:0] data_rdata,
  input core_sfr_pkg::mem_req_t mem_req,
  input wire logic [7:0] acc_value,
  input logic acc_load,
  input logic [7:0] acc_wdata,
  input core_sfr_pkg::alu_flags_t alu_flags,
  input wire logic kick_watchdog_instr,
  input wire logic halt_instr,
  input wire logic watchdog_timeout,
  input wire logic [PC_WIDTH-1:0] pc_now,
  input logic [PC_WIDTH-1:0] pc_load_value,
  input logic pc_load,
  input logic pipe_stall,
  input wire logic table_read,
  input wire logic [15:0] table_word,
  input logic [7:0] table_low_data,
  input logic table_low_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Local decode of the request
  wire logic loc = !data_req.ext && data_req.addr[10:8] == 3'h0;
  wire logic any = data_req.rd || data_req.wr;
  wire logic rd_flags = data_req.rd && loc && data_req.addr[7:0] == ADDR_FLAGS;
  property p_acc_wr;
    data_req.wr && loc && data_req.addr[7:0] == ADDR_ACC |-> acc_load && acc_wdata == data_req.wdata;
  endproperty
  a_acc_wr: assert property (p_acc_wr) else $error("accumulator write not passed on");
  property p_acc_rd;
    data_req.rd && loc && data_req.addr[7:0] == ADDR_ACC |-> data_rdata == acc_value;
  endproperty
  a_acc_rd: assert property (p_acc_rd) else $error("accumulator read wrong");
  property p_ind0;
    any && loc && data_req.addr[7:0] == ADDR_IND0 && mem_req.en |-> mem_req.sector == SECTOR_ZERO;
  endproperty
  a_ind0: assert property (p_ind0) else $error("port zero left sector zero");
  property p_ext;
    any && data_req.ext && mem_req.en |-> mem_req.sector == {5'h00, data_req.addr[10:8]} &&
      mem_req.addr == data_req.addr[7:0];
  endproperty
  a_ext: assert property (p_ext) else $error("extended address split wrong");
  property p_pcl;
    data_req.wr && loc && data_req.addr[7:0] == ADDR_PCLO && !pipe_stall |->
      pc_load && pc_load_value == {pc_now[PC_WIDTH-1:8], data_req.wdata} ##1 pipe_stall;
  endproperty
  a_pcl: assert property (p_pcl) else $error("program counter low write wrong");
  property p_table;
    table_read |=> table_low_valid && table_low_data == $past(table_word[7:0]);
  endproperty
  a_table: assert property (p_table) else $error("table low byte wrong");
  property p_kick;
    kick_watchdog_instr && !halt_instr && !watchdog_timeout ##1 rd_flags |-> data_rdata[5:4] == 2'b00;
  endproperty
  a_kick: assert property (p_kick) else $error("kick left system flags set");
  property p_halt;
    halt_instr && !watchdog_timeout ##1 rd_flags |-> data_rdata[5:4] == 2'b01;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_zero;
    alu_flags.kind == ALU_LOGIC ##1 rd_flags |-> data_rdata[FLAG_Z] == ($past(alu_flags.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_bank;
    data_req.rd && loc && data_req.addr[7:0] == ADDR_BANK |-> data_rdata[7:2] == 6'h00;
  endproperty
  a_bank: assert property (p_bank) else $error("bank upper bits not zero");
  c_pcl: cover property (pc_load ##1 pipe_stall);
  c_table: cover property (table_read ##1 table_low_valid);
  c_halt: cover property (halt_instr ##1 rd_flags);
endmodule : core_sfr_props
bind core_special_registers core_sfr_props #(.PC_WIDTH(PC_WIDTH), .TBL_WIDTH(TBL_WIDTH)) props_u (
  .clk(clk), .rst_n(rst_n), .data_req(data_req), .data_rdata(data_rdata), .mem_req(mem_req),
  .acc_value(acc_value), .acc_load(acc_load), .acc_wdata(acc_wdata), .alu_flags(alu_flags),
  .kick_watchdog_instr(kick_watchdog_instr), .halt_instr(halt_instr), .watchdog_timeout(watchdog_timeout),
  .pc_now(pc_now), .pc_load_value(pc_load_value), .pc_load(pc_load), .pipe_stall(pipe_stall),
  .table_read(table_read), .table_word(table_word), .table_low_data(table_low_data),
  .table_low_valid(table_low_valid));

//--- dv/tb_core_special_registers.sv
`timescale 1ns/100ps
module tb_core_special_registers;
  import core_sfr_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  data_req_t data_req = '0;
  mem_req_t mem_req;
  alu_flags_t alu_flags = '0;
  logic [7:0] data_rdata, acc_wdata, table_low_data;
  logic data_hit, acc_load, pc_load, pipe_stall, table_low_valid;
  logic kick = 0, halt = 0, tmo = 0, tbl_rd = 0;
  logic [12:0] pc_now = 13'h1234, pc_load_value, branch_address;
  logic [10:0] target = 11'h155;
  logic [15:0] table_address, table_word = 16'hABCD;
  logic [7:0] acc_value = 8'h3C;
  // Pattern memory so a wrong redirect shows up in the data
  wire logic [7:0] mem_rdata = mem_req.addr ^ mem_req.sector ^ 8'hA5;
  int miscompares = 0, n_compared = 0, cyc = 0;
  core_special_registers dut_u (.clk(clk), .rst_n(rst_n), .data_req(data_req), .data_rdata(data_rdata),
    .data_hit(data_hit), .mem_req(mem_req), .mem_rdata(mem_rdata), .acc_value(acc_value),
    .acc_load(acc_load), .acc_wdata(acc_wdata), .alu_flags(alu_flags), .kick_watchdog_instr(kick),
    .halt_instr(halt), .watchdog_timeout(tmo), .pc_now(pc_now), .pc_load_value(pc_load_value),
    .pc_load(pc_load), .pipe_stall(pipe_stall), .branch_instr(1'b0), .branch_target(target),
    .branch_address(branch_address), .table_read(tbl_rd), .table_address(table_address),
    .table_word(table_word), .table_low_data(table_low_data), .table_low_valid(table_low_valid));
  always #2 clk = ~clk;
  // ==========================================
  // Hang guard, far above the fewer than a hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // ==========================================
  // One access per cycle; sector nonzero means extended
  task acc_op(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d, input logic [2:0] s);
    @(negedge clk);
    data_req = '{r, w, s != 3'h0, {s, a}, d};
    #1;
  endtask : acc_op
  task wr(input logic [7:0] a, input logic [7:0] d);
    acc_op(1'b0, 1'b1, a, d, 3'h0);
  endtask : wr
  task rd(input logic [7:0] a);
    acc_op(1'b1, 1'b0, a, 8'h00, 3'h0);
  endtask : rd
  task step(input alu_flags_t f, input logic [2:0] sig, input logic [7:0] e);
    @(negedge clk);
    data_req = '0;
    alu_flags = f;
    {kick, halt, tmo} = sig;
    @(negedge clk);
    alu_flags = '0;
    {kick, halt, tmo} = 3'h0;
    data_req = '{1'b1, 1'b0, 1'b0, {3'h0, ADDR_FLAGS}, 8'h00};
    #1;
    chk("flags", data_rdata, e);
  endtask : step
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    rd(ADDR_BANK);
    chk("bank_rst", data_rdata, 16'h0000);
    rd(ADDR_FLAGS);
    chk("flags_rst", data_rdata, 16'h0000);
    for (int b = 0; b < 4; b++)
    begin
      wr(ADDR_BANK, {6'h3F, b[1:0]});
      rd(ADDR_BANK);
      chk("bank", data_rdata, 16'(b));
      chk("branch", 16'(branch_address), {3'h0, b[1:0], target});
    end
    $display("test bank done");
    wr(ADDR_PTR0, 8'h40);
    rd(ADDR_PTR0);
    chk("ptr0", data_rdata, 16'h0040);
    rd(ADDR_IND0);
    chk("ind0", {mem_req.sector, mem_req.addr}, 16'h0040);
    chk("ind0_d", data_rdata, 16'h00E5);
    chk("ind0_hit", {data_hit, mem_req.en}, 16'h0001);
    wr(ADDR_P1LO, 8'h40);
    wr(ADDR_P1SEC, 8'h01);
    rd(ADDR_IND1);
    chk("ind1", {mem_req.sector, mem_req.addr}, 16'h0140);
    chk("ind1_d", data_rdata, 16'h00E4);
    wr(ADDR_P2LO, 8'h22);
    wr(ADDR_P2SEC, 8'h05);
    wr(ADDR_IND2, 8'h5A);
    chk("ind2", {mem_req.sector, mem_req.addr}, 16'h0522);
    chk("ind2_w", {mem_req.wr, mem_req.wdata}, 16'h015A);
    wr(ADDR_PTR0, ADDR_IND0);
    rd(ADDR_IND0);
    chk("own_port", {mem_req.en, data_rdata}, 16'h0000);
    acc_op(1'b1, 1'b0, 8'hF0, 8'h00, 3'h1);
    chk("ext", {mem_req.sector, mem_req.addr}, 16'h01F0);
    chk("ext_d", data_rdata, 16'h0054);
    $display("test pointers done");
    rd(ADDR_ACC);
    chk("acc_rd", data_rdata, 16'h003C);
    chk("acc_hit", {data_hit, mem_req.en}, 16'h0002);
    wr(ADDR_ACC, 8'h99);
    chk("acc_wr", {acc_load, acc_wdata}, 16'h0199);
    wr(ADDR_PCLO, 8'h56);
    chk("pcl", {pc_load, pc_load_value}, 16'h3256);
    rd(ADDR_ACC);
    chk("stall", pipe_stall, 16'h0001);
    $display("test acc pcl done");
    wr(ADDR_TBLO, 8'h34);
    wr(ADDR_TBHI, 8'h12);
    @(negedge clk);
    data_req = '0;
    tbl_rd = 1;
    chk("tbl_addr", table_address, 16'h1234);
    @(negedge clk);
    tbl_rd = 0;
    chk("tbl_low", {table_low_valid, table_low_data}, 16'h01CD);
    rd(ADDR_TBRH);
    chk("tbl_high", data_rdata, 16'h00AB);
    $display("test table done");
    wr(ADDR_FLAGS, 8'hFF);
    rd(ADDR_FLAGS);
    chk("flags_wr", data_rdata, 16'h000F);
    step('{ALU_ADD, 8'h80, 1'b0, 1'b1, 1'b1}, 3'h0, 8'h0A);
    step('{ALU_SUB, 8'h00, 1'b1, 1'b1, 1'b1}, 3'h0, 8'h47);
    step('{ALU_SBC, 8'h01, 1'b1, 1'b0, 1'b0}, 3'h0, 8'h89);
    step('{ALU_LOGIC, 8'h00, 1'b0, 1'b0, 1'b0}, 3'h0, 8'h8D);
    step('{ALU_ROTC, 8'h00, 1'b0, 1'b0, 1'b0}, 3'h0, 8'h8C);
    step('0, 3'b010, 8'h9C);
    step('0, 3'b001, 8'hBC);
    step('0, 3'b010, 8'h9C);
    step('0, 3'b100, 8'h8C);
    step('0, 3'b101, 8'hAC);
    $display("test flags done");
    give_verdict();
  end
endmodule : tb_core_special_registers

//--- hdl/core_sfr_pkg.sv
package core_sfr_pkg;

  // ==========================================
  // Register addresses in sector 0
  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_P1LO = 8'h03;
  localparam logic [7:0] ADDR_P1SEC = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h05;
  localparam logic [7:0] ADDR_PCLO = 8'h06;
  localparam logic [7:0] ADDR_TBLO = 8'h07;
  localparam logic [7:0] ADDR_TBRH = 8'h08;
  localparam logic [7:0] ADDR_TBHI = 8'h09;
  localparam logic [7:0] ADDR_FLAGS = 8'h0A;
  localparam logic [7:0] ADDR_BANK = 8'h0B;
  localparam logic [7:0] ADDR_IND2 = 8'h0C;
  localparam logic [7:0] ADDR_P2LO = 8'h0D;
  localparam logic [7:0] ADDR_P2SEC = 8'h0E;
  localparam logic [7:0] SECTOR_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================
  // Field positions of the flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_PDF = 4;
  localparam int FLAG_TO = 5;
  localparam int FLAG_CZ = 6;
  localparam int FLAG_SC = 7;
  localparam logic [7:0] FLAGS_WRITABLE = 8'h0F;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ==========================================
  // Arithmetic flag update kinds
  typedef enum logic [2:0]
  {
    ALU_NONE = 3'h0,
    ALU_ADD = 3'h1,
    ALU_SUB = 3'h2,
    ALU_SBC = 3'h3,
    ALU_LOGIC = 3'h4,
    ALU_ROTC = 3'h5
  } alu_kind_t;

  typedef struct packed
  {
    alu_kind_t kind;
    logic [7:0] result;
    logic carry;
    logic nibble_carry;
    logic carry_into_msb;
  } alu_flags_t;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic ext;
    logic [10:0] addr;
    logic [7:0] wdata;
  } data_req_t;

  typedef struct packed
  {
    logic en;
    logic [7:0] sector;
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } mem_req_t;

  // Two-cycle instruction step machine for a program counter write
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b01,
    ST_DUMMY = 2'b10
  } pc_state_t;

endpackage : core_sfr_pkg

//--- hdl/core_special_registers.sv
// Operation
// - Indirect port accesses go to the location held in the paired pointer.
// - Pointer zero with port zero reaches sector zero only.
// - Pointers one and two: high byte selects sector, low byte selects location.
// - All pointers are real registers, readable and writable like any other.
// - Extended direct addresses: upper bits give sector, low byte the location.
// - Bank select two bits pick banks 0 to 3, reset to zero.
// - Upper six bank select bits read zero.
// - Jumps and calls target the selected program bank; software sets it first.
// - Program counter low write jumps within page and adds one dummy cycle.
// - Table read fetches word at table pointers; high byte into table-high register.
// - Software writes to flags leave watchdog and sleep flags unchanged.
// - Carry set on add carry or no subtract borrow; rotates also update.
// - Nibble carry set on low nibble carry or no nibble borrow.
// - Zero flag set when result is zero.
// - Overflow set when carry into and out of MSB differ.
// - Sleep flag clears on power-up or watchdog kick, sets on halt.
// - Watchdog flag clears on power-up, kick or halt, sets on timeout.
// - Sign-xor flag is overflow XOR result MSB.
// - Chained zero: equals zero on subtract, ANDs with zero on subtract-with-borrow.
// - Upper four flags read-only; watchdog and sleep flags power up zero.
// - Flags are not saved on interrupt or call; software saves them.
// - No direct register move; data passes through the accumulator.
// - Indirect port locations read zero and ignore writes.
`timescale 1ns/100ps
module core_special_registers
  import core_sfr_pkg::*;
#(
  parameter int PC_WIDTH = 13,
  parameter int TBL_WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input core_sfr_pkg::data_req_t data_req,
  output logic [7:0] data_rdata,
  output logic data_hit,
  output core_sfr_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] acc_value,
  output logic acc_load,
  output logic [7:0] acc_wdata,
  input core_sfr_pkg::alu_flags_t alu_flags,
  input wire logic kick_watchdog_instr,
  input wire logic halt_instr,
  input wire logic watchdog_timeout,
  input wire logic [PC_WIDTH-1:0] pc_now,
  output logic [PC_WIDTH-1:0] pc_load_value,
  output logic pc_load,
  output logic pipe_stall,
  input wire logic branch_instr,
  input wire logic [PC_WIDTH-3:0] branch_target,
  output logic [PC_WIDTH-1:0] branch_address,
  input wire logic table_read,
  output logic [TBL_WIDTH-1:0] table_address,
  input wire logic [15:0] table_word,
  output logic [7:0] table_low_data,
  output logic table_low_valid
);
  import core_sfr_pkg::*;

  // ==========================================
  // Storage
  logic [7:0] sector0_pointer_q;
  logic [7:0] pointer_one_low_q;
  logic [7:0] pointer_one_sector_q;
  logic [7:0] pointer_two_low_q;
  logic [7:0] pointer_two_sector_q;
  logic [7:0] table_pointer_low_q;
  logic [7:0] table_pointer_high_q;
  logic [7:0] table_read_high_q;
  logic [1:0] program_bank_select_q;
  logic [7:0] core_flags_q;
  logic [7:0] core_flags_d;
  pc_state_t pc_state_q;
  logic [7:0] local_rdata;
  logic local_hit;
  logic [7:0] eff_sector;
  logic [7:0] eff_addr;
  logic is_local;

  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == ADDR_IND0) || (a == ADDR_IND1) || (a == ADDR_IND2);
  endfunction : is_port

  // ==========================================
  // Address redirection
  always_comb
  begin
    eff_sector = {5'h00, data_req.addr[10:8]};
    eff_addr = data_req.addr[7:0];
    if (!data_req.ext && data_req.addr[7:0] == ADDR_IND0)
    begin
      eff_sector = SECTOR_ZERO;
      eff_addr = sector0_pointer_q;
    end
    else if (!data_req.ext && data_req.addr[7:0] == ADDR_IND1)
    begin
      eff_sector = pointer_one_sector_q;
      eff_addr = pointer_one_low_q;
    end
    else if (!data_req.ext && data_req.addr[7:0] == ADDR_IND2)
    begin
      eff_sector = pointer_two_sector_q;
      eff_addr = pointer_two_low_q;
    end
    else if (!data_req.ext)
    begin
      eff_sector = SECTOR_ZERO;
    end
  end

  // Pointer landing on a port location reads zero, not a loop
  assign is_local = (eff_sector == SECTOR_ZERO) && (eff_addr <= ADDR_P2SEC);
  assign mem_req.en = (data_req.rd || data_req.wr) && !is_local;
  assign mem_req.sector = eff_sector;
  assign mem_req.addr = eff_addr;
  assign mem_req.wr = data_req.wr && !is_local;
  assign mem_req.wdata = data_req.wdata;

  // ==========================================
  // Local read mux
  always_comb
  begin
    local_rdata = BYTE_ZERO;
    local_hit = 1'b1;
    if (is_port(eff_addr))
    begin
      local_rdata = BYTE_ZERO;
    end
    else if (eff_addr == ADDR_PTR0)
    begin
      local_rdata = sector0_pointer_q;
    end
    else if (eff_addr == ADDR_P1LO)
    begin
      local_rdata = pointer_one_low_q;
    end
    else if (eff_addr == ADDR_P1SEC)
    begin
      local_rdata = pointer_one_sector_q;
    end
    else if (eff_addr == ADDR_P2LO)
    begin
      local_rdata = pointer_two_low_q;
    end
    else if (eff_addr == ADDR_P2SEC)
    begin
      local_rdata = pointer_two_sector_q;
    end
    else if (eff_addr == ADDR_ACC)
    begin
      local_rdata = acc_value;
    end
    else if (eff_addr == ADDR_PCLO)
    begin
      local_rdata = pc_now[7:0];
    end
    else if (eff_addr == ADDR_TBLO)
    begin
      local_rdata = table_pointer_low_q;
    end
    else if (eff_addr == ADDR_TBRH)
    begin
      local_rdata = table_read_high_q;
    end
    else if (eff_addr == ADDR_TBHI)
    begin
      local_rdata = table_pointer_high_q;
    end
    else if (eff_addr == ADDR_FLAGS)
    begin
      local_rdata = core_flags_q;
    end
    else if (eff_addr == ADDR_BANK)
    begin
      local_rdata = {6'h00, program_bank_select_q};
    end
    else
    begin
      local_hit = 1'b0;
    end
  end

  assign data_rdata = is_local ? local_rdata : mem_rdata;
  assign data_hit = data_req.rd && is_local && local_hit;

  // ==========================================
  // Pointer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sector0_pointer_q <= BYTE_ZERO;
      pointer_one_low_q <= BYTE_ZERO;
      pointer_one_sector_q <= BYTE_ZERO;
      pointer_two_low_q <= BYTE_ZERO;
      pointer_two_sector_q <= BYTE_ZERO;
    end
    else if (data_req.wr && is_local)
    begin
      if (eff_addr == ADDR_PTR0)
      begin
        sector0_pointer_q <= data_req.wdata;
      end
      else if (eff_addr == ADDR_P1LO)
      begin
        pointer_one_low_q <= data_req.wdata;
      end
      else if (eff_addr == ADDR_P1SEC)
      begin
        pointer_one_sector_q <= data_req.wdata;
      end
      else if (eff_addr == ADDR_P2LO)
      begin
        pointer_two_low_q <= data_req.wdata;
      end
      else if (eff_addr == ADDR_P2SEC)
      begin
        pointer_two_sector_q <= data_req.wdata;
      end
    end
  end

  // ==========================================
  // Accumulator write-through
  assign acc_load = data_req.wr && is_local && (eff_addr == ADDR_ACC);
  assign acc_wdata = data_req.wdata;

  // ==========================================
  // Program bank and branch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_bank_select_q <= BANK_RESET;
    end
    else if (data_req.wr && is_local && eff_addr == ADDR_BANK)
    begin
      program_bank_select_q <= data_req.wdata[1:0];
    end
  end

  assign branch_address = {program_bank_select_q, branch_target};

  // ==========================================
  // Program counter low write
  assign pc_load = data_req.wr && is_local && (eff_addr == ADDR_PCLO) && (pc_state_q == ST_RUN);
  assign pc_load_value = {pc_now[PC_WIDTH-1:8], data_req.wdata};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_state_q <= ST_RUN;
    end
    else
    begin
      case (pc_state_q)
        ST_RUN:
        begin
          if (pc_load)
          begin
            pc_state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          pc_state_q <= ST_RUN;
        end
        default:
        begin
          pc_state_q <= ST_RUN;
        end
      endcase
    end
  end

  assign pipe_stall = (pc_state_q == ST_DUMMY);

  // ==========================================
  // Table read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_pointer_low_q <= BYTE_ZERO;
      table_pointer_high_q <= BYTE_ZERO;
    end
    else if (data_req.wr && is_local && eff_addr == ADDR_TBLO)
    begin
      table_pointer_low_q <= data_req.wdata;
    end
    else if (data_req.wr && is_local && eff_addr == ADDR_TBHI)
    begin
      table_pointer_high_q <= data_req.wdata;
    end
  end

  assign table_address = TBL_WIDTH'({table_pointer_high_q, table_pointer_low_q});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_read_high_q <= BYTE_ZERO;
      table_low_data <= BYTE_ZERO;
      table_low_valid <= 1'b0;
    end
    else
    begin
      table_low_valid <= table_read;
      if (table_read)
      begin
        table_read_high_q <= table_word[15:8];
        table_low_data <= table_word[7:0];
      end
    end
  end

  // ==========================================
  // Flags
  always_comb
  begin
    core_flags_d = core_flags_q;
    if (data_req.wr && is_local && eff_addr == ADDR_FLAGS)
    begin
      core_flags_d = (core_flags_q & ~FLAGS_WRITABLE) | (data_req.wdata & FLAGS_WRITABLE);
    end
    case (alu_flags.kind)
      ALU_ADD, ALU_SUB, ALU_SBC:
      begin
        core_flags_d[FLAG_C] = alu_flags.carry;
        core_flags_d[FLAG_AC] = alu_flags.nibble_carry;
        core_flags_d[FLAG_Z] = (alu_flags.result == BYTE_ZERO);
        core_flags_d[FLAG_OV] = alu_flags.carry_into_msb ^ alu_flags.carry;
        core_flags_d[FLAG_SC] = core_flags_d[FLAG_OV] ^ alu_flags.result[7];
        if (alu_flags.kind == ALU_SUB)
        begin
          core_flags_d[FLAG_CZ] = core_flags_d[FLAG_Z];
        end
        else if (alu_flags.kind == ALU_SBC)
        begin
          core_flags_d[FLAG_CZ] = core_flags_q[FLAG_CZ] & core_flags_d[FLAG_Z];
        end
      end
      ALU_LOGIC:
      begin
        core_flags_d[FLAG_Z] = (alu_flags.result == BYTE_ZERO);
      end
      ALU_ROTC:
      begin
        core_flags_d[FLAG_C] = alu_flags.carry;
      end
      default:
      begin
      end
    endcase
    if (kick_watchdog_instr)
    begin
      core_flags_d[FLAG_PDF] = 1'b0;
      core_flags_d[FLAG_TO] = 1'b0;
    end
    if (halt_instr)
    begin
      core_flags_d[FLAG_PDF] = 1'b1;
      core_flags_d[FLAG_TO] = 1'b0;
    end
    // Timeout wins so a same-cycle kick cannot hide it
    if (watchdog_timeout)
    begin
      core_flags_d[FLAG_TO] = 1'b1;
    end
  end

  // Flags are never stacked on call or interrupt
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_flags_q <= FLAGS_RESET;
    end
    else
    begin
      core_flags_q <= core_flags_d;
    end
  end

endmodule : core_special_registers
